// [tb/oad_decoder_monitor.sv]
/* checker on the decoder's ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module oad_decoder_monitor (
    // clock and reset
    input logic clk,
    input logic rst,
    // fetch side
    input logic inValid,
    input logic [7:0] formByte,
    input logic [7:0] sibByte,
    input logic addrSize32,
    input logic flowToggleBit,
    // decoded side
    input logic outValid,
    input logic sibUsed,
    input logic baseValid,
    input logic [2:0] baseReg,
    input logic [3:0] scaleFactor,
    input logic [1:0] dispKind,
    input logic segSel,
    input logic rmIsDest
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [1:0] fm = formByte[7:6];
    wire mem = inValid && addrSize32 && fm != 2'h3;
    wire sib = mem && formByte[2:0] == 3'h4;
    wire [2:0] bs = sib ? sibByte[2:0] : formByte[2:0];
    ////////////////////////////////////////////////////////////////////////
    property p_ack; 1'b1 |=> outValid == $past(inValid); endproperty
    a_ack: assert property (p_ack) else $error("answer strobe wrong");
    property p_sib; inValid |=> sibUsed == $past(sib); endproperty
    a_sib: assert property (p_sib) else $error("index byte use");
    property p_dsp; mem && fm != 2'h0 |=> dispKind == $past(fm); endproperty
    a_dsp: assert property (p_dsp) else $error("disp kind");
    property p_stk; sib && bs == 3'h4 |=> baseReg == 3'h4 && segSel;
    endproperty
    a_stk: assert property (p_stk) else $error("stack base");
    property p_nob; mem && fm == 2'h0 && bs == 3'h5 |=>
        !baseValid && dispKind == 2'h2 && !segSel; endproperty
    a_nob: assert property (p_nob) else $error("no base");
    property p_frm; mem && fm != 2'h0 && bs == 3'h5 |=>
        baseValid && baseReg == 3'h5 && segSel; endproperty
    a_frm: assert property (p_frm) else $error("frame base");
    property p_scl; sib |=> scaleFactor == 4'h1 << $past(sibByte[7:6]);
    endproperty
    a_scl: assert property (p_scl) else $error("scale");
    property p_reg; inValid && fm == 2'h3 |=> !baseValid && dispKind == 2'h0;
    endproperty
    a_reg: assert property (p_reg) else $error("reg form");
    property p_dir; inValid |=> rmIsDest != $past(flowToggleBit); endproperty
    a_dir: assert property (p_dir) else $error("direction");
    c_sib: cover property (sib && fm == 2'h0 && bs == 3'h5);
    c_frm: cover property (mem && fm == 2'h2 && bs == 3'h5);
    c_reg: cover property (inValid && fm == 2'h3);
endmodule

// [tb/oad_fetch_model.sv]
/* fetch-side model: presents one decode request per call.
   assumes one bench process calls send and idle. */
`timescale 1ns/1ps
module oad_fetch_model (
    // clock
    input logic clk,
    // request lines
    output logic inValid,
    output logic [62:0] req
);
    initial begin
        inValid = 1'b0;
        req = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // drive just after the edge so the next edge takes it cleanly
    task automatic send(input logic [62:0] r);
        logic [62:0] v;
        v = r;
        if (r[52:50] == 3'h4) v[54:53] = 2'h0;
        @(posedge clk);
        #1;
        req = v;
        inValid = 1'b1;
    endtask
    task automatic idle();
        @(posedge clk);
        #1;
        inValid = 1'b0;
    endtask
endmodule

// [tb/testbench.sv]
/* bench for the decoder: random requests, expectations queued.
   assumes the fetch model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin badCount++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
    logic clk = 1'b0, rst = 1'b1, inValid;
    logic [62:0] req;
    logic [7:0] formByte, sibByte;
    logic addrSize32, dataSize32, operandSizeBit, flowToggleBit;
    logic immWidenBit, imm8Only, outValid, use32Table, isRegOperand, sibUsed;
    logic baseValid, indexValid, segSel, rmHighByte, otherHighByte;
    logic rmIsDest, condTrue;
    logic [31:0] immIn, immOut;
    logic [3:0] condCodeField, scaleFactor;
    logic [4:0] flagsIn;
    logic [2:0] baseReg, indexReg, rmRegNum, otherRegNum;
    logic [1:0] dispKind, rmWidth;
    logic [61:0] act, e, expQ[$];
    int badCount = 0, totalChecks = 0, cycles = 0;
    assign {formByte, sibByte, addrSize32, dataSize32, operandSizeBit,
        flowToggleBit, immWidenBit, imm8Only, immIn, condCodeField,
        flagsIn} = req;
    assign act = {use32Table, isRegOperand, sibUsed, baseValid,
        baseValid ? baseReg : 3'h0, indexValid, indexValid ? indexReg : 3'h0,
        scaleFactor, dispKind, segSel, isRegOperand ? {rmRegNum, rmHighByte,
        rmWidth} : 6'h0, otherRegNum, otherHighByte, rmIsDest, immOut, condTrue};
    oad_fetch_model i_fetch (.clk, .inValid, .req);
    oad_decoder i_dut (.clk, .rst, .inValid, .formByte, .sibByte, .addrSize32,
        .dataSize32, .operandSizeBit, .flowToggleBit, .immWidenBit, .imm8Only,
        .immIn, .condCodeField, .flagsIn, .outValid, .use32Table,
        .isRegOperand, .sibUsed, .baseValid, .baseReg, .indexValid, .indexReg,
        .scaleFactor, .dispKind, .segSel, .rmRegNum, .rmHighByte, .rmWidth,
        .otherRegNum, .otherHighByte, .rmIsDest, .immOut, .condTrue);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] rs(logic [2:0] k);
        return operandSizeBit ? {k, 1'b0} : {1'b0, k[1:0], k[2]};
    endfunction
    function automatic logic [61:0] expNow();
        logic [1:0] f;
        logic [2:0] b;
        logic sib, mem, bv, iv, lt;
        logic [7:0] t;
        logic [31:0] im;
        f = formByte[7:6];
        mem = addrSize32 && f != 2'h3;
        sib = mem && formByte[2:0] == 3'h4;
        b = sib ? sibByte[2:0] : formByte[2:0];
        bv = mem && !(f == 2'h0 && b == 3'h5);
        iv = sib && sibByte[5:3] != 3'h4;
        im = operandSizeBit && imm8Only ?
            {{24{immWidenBit & immIn[7]}}, immIn[7:0]} : immIn;
        if (operandSizeBit && imm8Only && !dataSize32) im[31:16] = 16'h0;
        lt = flagsIn[3] ^ flagsIn[4];
        t = {lt | flagsIn[2], lt, flagsIn[1], flagsIn[3],
            flagsIn[0] | flagsIn[2], flagsIn[2], flagsIn[0], flagsIn[4]};
        return {addrSize32, f == 2'h3, sib, bv, bv ? b : 3'h0, iv,
            iv ? sibByte[5:3] : 3'h0, sib ? 4'h1 << sibByte[7:6] : 4'h1,
            !mem ? 2'h0 : f == 2'h0 ? {b == 3'h5, 1'b0} : f,
            mem && (sib && b == 3'h4 || f != 2'h0 && b == 3'h5),
            f == 2'h3 ? {rs(formByte[2:0]), operandSizeBit & dataSize32,
            operandSizeBit & !dataSize32} : 6'h0, rs(formByte[5:3]),
            !flowToggleBit, im, t[condCodeField[3:1]] ^ condCodeField[0]};
    endfunction
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            badCount++;
            wrapUp();
        end
    end
    initial forever begin
        @(posedge clk);
        #2;
        if (outValid !== 1'b0) begin
            e = expQ.size() ? expQ.pop_front() : ~act;
            `CHK(act, e)
        end
    end
    initial begin
        void'($urandom(47014));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        `CHK({outValid, scaleFactor, dispKind, immOut}, {7'h04, 32'h0})
        repeat (2000) begin
            i_fetch.send(63'({$urandom, $urandom}));
            #1 expQ.push_back(expNow());
            repeat ($urandom % 3) i_fetch.idle();
        end
        i_fetch.idle();
        repeat (3) @(posedge clk);
        `CHK(expQ.size(), 0)
        wrapUp();
    end
endmodule
bind oad_decoder oad_decoder_monitor i_mon (.clk, .rst, .inValid, .formByte,
    .sibByte, .addrSize32, .flowToggleBit, .outValid, .sibUsed, .baseValid,
    .baseReg, .scaleFactor, .dispKind, .segSel, .rmIsDest);

// [verilog/oad_decoder.v]
/*
 * operand address decoder: decodes the addressing-form byte, the optional
 * scaled-index byte, direction, sign-widen and condition fields, and
 * registers the decoded controls for address generation and execute.
 * assumes the fetch path presents both bytes, the immediate and the flags
 * together with a one-cycle valid strobe, all from the core clock domain.
 */
`timescale 1ns/1ps
`include "oad_decoder_regs.vh"

module oad_decoder (
    // clock and reset
    input wire clk,
    input wire rst,
    // fetch side
    input wire inValid,
    input wire [7:0] formByte,
    input wire [7:0] sibByte,
    input wire addrSize32,
    input wire dataSize32,
    input wire operandSizeBit,
    input wire flowToggleBit,
    input wire immWidenBit,
    input wire imm8Only,
    input wire [31:0] immIn,
    input wire [3:0] condCodeField,
    input wire [4:0] flagsIn,
    // decoded address controls
    output wire outValid,
    output wire use32Table,
    output wire isRegOperand,
    output wire sibUsed,
    output wire baseValid,
    output wire [2:0] baseReg,
    output wire indexValid,
    output wire [2:0] indexReg,
    output wire [3:0] scaleFactor,
    output wire [1:0] dispKind,
    output wire segSel,
    // decoded register operand
    output wire [2:0] rmRegNum,
    output wire rmHighByte,
    output wire [1:0] rmWidth,
    output wire [2:0] otherRegNum,
    output wire otherHighByte,
    output wire rmIsDest,
    // immediate and condition
    output wire [31:0] immOut,
    output wire condTrue
);

    ////////////////////////////////////////////////////////////////////////
    // field split
    wire [1:0] form = formByte[`OAD_FORM_HI:`OAD_FORM_LO];
    wire [2:0] selField = formByte[`OAD_SEL_HI:`OAD_SEL_LO];
    wire [2:0] locator = formByte[`OAD_LOC_HI:`OAD_LOC_LO];
    wire [1:0] scaleCode = sibByte[`OAD_SCALE_HI:`OAD_SCALE_LO];
    wire [2:0] indexCode = sibByte[`OAD_INDEX_HI:`OAD_INDEX_LO];
    wire [2:0] baseCode = sibByte[`OAD_BASE_HI:`OAD_BASE_LO];
    wire [2:0] condSel = condCodeField[3:1];
    wire flipBit = condCodeField[0];
    // flags: carry, parity, zero, sign, overflow
    wire fCarry = flagsIn[`OAD_FLAG_CARRY];
    wire fParity = flagsIn[`OAD_FLAG_PARITY];
    wire fZero = flagsIn[`OAD_FLAG_ZERO];
    wire fSign = flagsIn[`OAD_FLAG_SIGN];
    wire fOvf = flagsIn[`OAD_FLAG_OVF];

    ////////////////////////////////////////////////////////////////////////
    // address decode
    reg sibNext;
    reg baseValidNext;
    reg [2:0] baseNext;
    reg indexValidNext;
    reg [2:0] indexNext;
    reg [3:0] scaleNext;
    reg [1:0] dispNext;
    reg segNext;

    always @* begin
        sibNext = 1'b0;
        baseValidNext = 1'b0;
        baseNext = 3'h0;
        indexValidNext = 1'b0;
        indexNext = 3'h0;
        scaleNext = 4'h1;
        dispNext = `OAD_DISP_NONE;
        segNext = `OAD_SEG_DATA;
        // 16-bit table lies outside this block; only 32-bit is decoded
        if (addrSize32 && form != `OAD_FORM_REG) begin
            case (form)
                `OAD_FORM_DISP8: dispNext = `OAD_DISP_SHORT;
                `OAD_FORM_DISP32: dispNext = `OAD_DISP_LONG;
                default: dispNext = `OAD_DISP_NONE;
            endcase
            if (locator == `OAD_CODE_SIB) begin
                sibNext = 1'b1;
                // index 100 means none; scale then assumed 00
                indexValidNext = (indexCode != `OAD_CODE_NOIDX);
                indexNext = indexCode;
                case (scaleCode)
                    2'h0: scaleNext = 4'h1;
                    2'h1: scaleNext = 4'h2;
                    2'h2: scaleNext = 4'h4;
                    default: scaleNext = 4'h8;
                endcase
                if (baseCode == `OAD_CODE_FRAME &&
                        form == `OAD_FORM_NODISP) begin
                    dispNext = `OAD_DISP_LONG;
                end else begin
                    baseValidNext = 1'b1;
                    baseNext = baseCode;
                    if (baseCode == `OAD_CODE_STACK ||
                            baseCode == `OAD_CODE_FRAME)
                        segNext = `OAD_SEG_STACK;
                end
            end else if (locator == `OAD_CODE_FRAME &&
                    form == `OAD_FORM_NODISP) begin
                dispNext = `OAD_DISP_LONG;
            end else begin
                baseValidNext = 1'b1;
                baseNext = locator;
                if (locator == `OAD_CODE_FRAME)
                    segNext = `OAD_SEG_STACK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register operands: narrow codes 100-111 are second bytes of 0-3
    wire rmIsReg = (form == `OAD_FORM_REG);
    wire rmHighNext = ~operandSizeBit & locator[2];
    wire [2:0] rmNumNext = operandSizeBit ? locator :
        {1'b0, locator[1:0]};
    wire otherHighNext = ~operandSizeBit & selField[2];
    wire [2:0] otherNumNext = operandSizeBit ? selField :
        {1'b0, selField[1:0]};
    // width: 0 byte, 1 word, 2 dword
    wire [1:0] widthNext = !operandSizeBit ? 2'h0 :
        (dataSize32 ? 2'h2 : 2'h1);

    ////////////////////////////////////////////////////////////////////////
    // immediate: widen only an 8-bit immediate into a wider destination
    reg [31:0] immNext;
    always @* begin
        immNext = immIn;
        if (imm8Only && operandSizeBit) begin
            if (immWidenBit)
                immNext = {{24{immIn[7]}}, immIn[7:0]};
            else
                immNext = {24'h000000, immIn[7:0]};
            if (!dataSize32)
                immNext = {16'h0000, immNext[15:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // condition evaluation
    reg condBase;
    always @* begin
        case (condSel)
            `OAD_CC_OVF: condBase = fOvf;
            `OAD_CC_BELOW: condBase = fCarry;
            `OAD_CC_ZERO: condBase = fZero;
            `OAD_CC_BEQ: condBase = fCarry | fZero;
            `OAD_CC_SIGN: condBase = fSign;
            `OAD_CC_PAR: condBase = fParity;
            `OAD_CC_LESS: condBase = fSign ^ fOvf;
            `OAD_CC_LEQ: condBase = (fSign ^ fOvf) | fZero;
            default: condBase = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers; the ports only mirror them
    reg outValidReg;
    reg use32TableReg;
    reg isRegOperandReg;
    reg sibUsedReg;
    reg baseValidReg;
    reg [2:0] baseRegReg;
    reg indexValidReg;
    reg [2:0] indexRegReg;
    reg [3:0] scaleFactorReg;
    reg [1:0] dispKindReg;
    reg segSelReg;
    reg [2:0] rmRegNumReg;
    reg rmHighByteReg;
    reg [1:0] rmWidthReg;
    reg [2:0] otherRegNumReg;
    reg otherHighByteReg;
    reg rmIsDestReg;
    reg [31:0] immOutReg;
    reg condTrueReg;

    ////////////////////////////////////////////////////////////////////////
    // answer strobe: a pulse exactly one cycle after each taken request
    always @(posedge clk) begin
        if (rst)
            outValidReg <= 1'b0;
        else
            outValidReg <= inValid;
    end

    ////////////////////////////////////////////////////////////////////////
    // address controls: load on a taken request, hold otherwise
    // (execute may read them in any cycle until the next request)
    always @(posedge clk) begin
        if (rst) begin
            use32TableReg <= 1'b0;
            isRegOperandReg <= 1'b0;
            sibUsedReg <= 1'b0;
            baseValidReg <= 1'b0;
            baseRegReg <= 3'h0;
            indexValidReg <= 1'b0;
            indexRegReg <= 3'h0;
            scaleFactorReg <= `OAD_RST_SCALE;
            dispKindReg <= `OAD_DISP_NONE;
            segSelReg <= `OAD_SEG_DATA;
        end else if (inValid) begin
            use32TableReg <= addrSize32;
            isRegOperandReg <= rmIsReg;
            sibUsedReg <= sibNext;
            baseValidReg <= baseValidNext;
            baseRegReg <= baseNext;
            indexValidReg <= indexValidNext;
            indexRegReg <= indexNext;
            scaleFactorReg <= scaleNext;
            dispKindReg <= dispNext;
            segSelReg <= segNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register operands and direction
    always @(posedge clk) begin
        if (rst) begin
            rmRegNumReg <= 3'h0;
            rmHighByteReg <= 1'b0;
            rmWidthReg <= 2'h0;
            otherRegNumReg <= 3'h0;
            otherHighByteReg <= 1'b0;
            rmIsDestReg <= 1'b0;
        end else if (inValid) begin
            rmRegNumReg <= rmNumNext;
            rmHighByteReg <= rmHighNext;
            rmWidthReg <= widthNext;
            otherRegNumReg <= otherNumNext;
            otherHighByteReg <= otherHighNext;
            rmIsDestReg <= ~flowToggleBit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // immediate and condition result; flags are taken with the request,
    // so a later flag change does not alter a decoded condition
    always @(posedge clk) begin
        if (rst) begin
            immOutReg <= 32'h00000000;
            condTrueReg <= 1'b0;
        end else if (inValid) begin
            immOutReg <= immNext;
            condTrueReg <= condBase ^ flipBit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ports mirror the output registers
    assign outValid = outValidReg;
    assign use32Table = use32TableReg;
    assign isRegOperand = isRegOperandReg;
    assign sibUsed = sibUsedReg;
    assign baseValid = baseValidReg;
    assign baseReg = baseRegReg;
    assign indexValid = indexValidReg;
    assign indexReg = indexRegReg;
    assign scaleFactor = scaleFactorReg;
    assign dispKind = dispKindReg;
    assign segSel = segSelReg;
    assign rmRegNum = rmRegNumReg;
    assign rmHighByte = rmHighByteReg;
    assign rmWidth = rmWidthReg;
    assign otherRegNum = otherRegNumReg;
    assign otherHighByte = otherHighByteReg;
    assign rmIsDest = rmIsDestReg;
    assign immOut = immOutReg;
    assign condTrue = condTrueReg;

endmodule

// [verilog/oad_decoder_regs.vh]
/*
 * constants for the operand address decoder: field positions, encodings
 * and register codes. assumes nothing; definitions only.
 */
`ifndef OAD_DECODER_REGS_VH
`define OAD_DECODER_REGS_VH

// addressing-form byte fields
`define OAD_FORM_HI 7
`define OAD_FORM_LO 6
`define OAD_SEL_HI 5
`define OAD_SEL_LO 3
`define OAD_LOC_HI 2
`define OAD_LOC_LO 0

// scaled-index byte fields
`define OAD_SCALE_HI 7
`define OAD_SCALE_LO 6
`define OAD_INDEX_HI 5
`define OAD_INDEX_LO 3
`define OAD_BASE_HI 2
`define OAD_BASE_LO 0

// addressing forms
`define OAD_FORM_NODISP 2'h0
`define OAD_FORM_DISP8 2'h1
`define OAD_FORM_DISP32 2'h2
`define OAD_FORM_REG 2'h3

// special locator codes
`define OAD_CODE_SIB 3'h4
`define OAD_CODE_NOIDX 3'h4
`define OAD_CODE_STACK 3'h4
`define OAD_CODE_FRAME 3'h5

// segment selections
`define OAD_SEG_DATA 1'h0
`define OAD_SEG_STACK 1'h1

// displacement kinds
`define OAD_DISP_NONE 2'h0
`define OAD_DISP_SHORT 2'h1
`define OAD_DISP_LONG 2'h2

// condition selectors (upper three bits of the condition field)
`define OAD_CC_OVF 3'h0
`define OAD_CC_BELOW 3'h1
`define OAD_CC_ZERO 3'h2
`define OAD_CC_BEQ 3'h3
`define OAD_CC_SIGN 3'h4
`define OAD_CC_PAR 3'h5
`define OAD_CC_LESS 3'h6
`define OAD_CC_LEQ 3'h7

// flag positions inside the flags input
`define OAD_FLAG_CARRY 0
`define OAD_FLAG_PARITY 1
`define OAD_FLAG_ZERO 2
`define OAD_FLAG_SIGN 3
`define OAD_FLAG_OVF 4

// reset value of the scale output (x1)
`define OAD_RST_SCALE 4'h1

`endif
